// File: hdl/scp_pkg.sv
// Constants and types of the serial command port
// Contract
// - The device is only a serial bus slave; the host starts everything.
// - While select is high, serial clock and data in are ignored.
// - Data lines change on falling edges and are sampled on rising edges.
// - Transfers are byte aligned, most significant bit first both ways.
// - Raising select abandons the transaction; next falling select starts anew.
// - First byte after select falls is the command byte.
// - Command 0x20 loads a 16-bit register address for later access.
// - Command 0x2D writes 16 or 32 following bits to the stored address.
// - Command 0x6D, one dummy byte, then 16 or 32 bits read out.
// - Command 0x5F fast buffer read; six dummy bytes precede valid data.
// - Next result is fetched internally while previous one shifts out.
// - Prefetch from the empty buffer raises an underflow error; only a prefetch at offset 0x00 raises it here.
package scp_pkg;

  localparam logic [7:0] CMD_LOAD_ADDRESS     = 8'h20;
  localparam logic [7:0] CMD_REGISTER_WRITE   = 8'h2d;
  localparam logic [7:0] CMD_REGISTER_READ    = 8'h6d;
  localparam logic [7:0] CMD_FAST_BUFFER_READ = 8'h5f;

  // Byte positions inside a frame
  localparam logic [2:0] IDX_COMMAND    = 3'h0;
  localparam logic [2:0] IDX_ADDR_HIGH  = 3'h1;
  localparam logic [2:0] IDX_ADDR_LOW   = 3'h2;
  localparam logic [2:0] IDX_READ_DATA  = 3'h2;
  localparam logic [2:0] IDX_LAST_DUMMY = 3'h6;
  localparam logic [2:0] IDX_WRAP_TOP   = 3'h7;
  localparam logic [2:0] IDX_WRAP_BASE  = 3'h4;
  localparam logic [1:0] SLOT_OFFSET    = 2'h1;
  localparam logic [1:0] SLOT_RESULT    = 2'h3;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] WR_HALF_BYTES  = 3'h2;
  localparam logic [2:0] WR_FULL_BYTES  = 3'h4;
  localparam int         SYNC_WIDTH     = 3;

  localparam logic [15:0] RESULT_BUFFER_READ_PORT = 16'h2068;

  typedef enum logic [2:0] {
    MODE_NONE  = 3'b000,
    MODE_ADDR  = 3'b001,
    MODE_WRITE = 3'b011,
    MODE_READ  = 3'b010,
    MODE_FAST  = 3'b110
  } scp_mode_e;

endpackage

// File: hdl/scp_sync.sv
// Two-stage synchroniser for pin inputs
module scp_sync #(
  parameter int WIDTH = 1
) (
  // System side
  input  wire logic             clock,
  input  wire logic             rst,
  // Pins and synchronised copy
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1_q <= '1;
      syncOut  <= '1;
    end else begin
      stage1_q <= pinIn;
      syncOut  <= stage1_q;
    end
  end

endmodule

// File: hdl/scp_top.sv
// Serial command port: slave shifter, command decode, internal bus master
module scp_top
  import scp_pkg::*;
(
  // System
  input  wire logic        clock,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic        mosi,
  output logic             miso,
  output logic             misoOeN,
  // Status and buffer state
  input  wire logic [7:0]  serialStatusByte,
  input  wire logic        bufEmpty,
  output logic             underflowErr,
  // Internal bus
  output logic             busReq,
  output logic             busWe,
  output logic             busWide,
  output logic [15:0]      busAddr,
  output logic [31:0]      busWdata,
  input  wire logic        busAck,
  input  wire logic [31:0] busRdata,
  input  wire logic        busRdWide
);

  logic csS, sclkS, mosiS;
  logic sclkPrev_q, csPrev_q;
  logic sclkRise, sclkFall, csFall, csRise, byteDone;
  logic [7:0] rxByte;

  scp_sync #(.WIDTH(SYNC_WIDTH)) uSync (
    .clock   (clock),
    .rst     (rst),
    .pinIn   ({csN, sclk, mosi}),
    .syncOut ({csS, sclkS, mosiS})
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      sclkPrev_q <= 1'b0;
      csPrev_q   <= 1'b1;
    end else begin
      sclkPrev_q <= sclkS;
      csPrev_q   <= csS;
    end
  end
  logic [2:0]  bitCnt_q, bitCnt_d, byteIdx_q, byteIdx_d, wrCnt_q, wrCnt_d;
  logic [6:0]  rxShift_q, rxShift_d;
  logic [7:0]  txShift_q, txShift_d, addrHi_q, addrHi_d, txSel, fetchOff;
  logic [23:0] txWord_q, txWord_d;
  logic [15:0] regAddr_q, regAddr_d;
  logic [31:0] wrData_q, wrData_d;
  logic        dataPhase_q, dataPhase_d, miso_q, miso_d, misoOeN_q, misoOeN_d;
  scp_mode_e   mode_q, mode_d;

  // Serial edges count only while selected
  assign sclkRise = sclkS & ~sclkPrev_q & ~csS;
  assign sclkFall = ~sclkS & sclkPrev_q & ~csS;
  assign csFall   = csPrev_q & ~csS;
  assign csRise   = ~csPrev_q & csS;
  assign rxByte   = {rxShift_q, mosiS};
  assign byteDone = sclkRise && bitCnt_q == BIT_LAST;
  logic [31:0] rdWord_q, rdWord_d, pre_q, pre_d;

  always_comb begin
    txSel  = serialStatusByte;
    txWord_d = txWord_q;
    if (mode_q == MODE_FAST && dataPhase_q) begin
      if (byteIdx_q[1:0] == SLOT_RESULT) begin
        txSel    = pre_q[31:24];
        txWord_d = pre_q[23:0];
      end else begin
        txSel    = txWord_q[23:16];
        txWord_d = {txWord_q[15:0], 8'h00};
      end
    end else if (mode_q == MODE_READ && byteIdx_q >= IDX_READ_DATA) begin
      if (byteIdx_q == IDX_READ_DATA) begin
        txSel    = rdWord_q[31:24];
        txWord_d = rdWord_q[23:0];
      end else begin
        txSel    = txWord_q[23:16];
        txWord_d = {txWord_q[15:0], 8'h00};
      end
    end
  end

  always_comb begin
    bitCnt_d    = bitCnt_q;
    byteIdx_d   = byteIdx_q;
    wrCnt_d     = wrCnt_q;
    rxShift_d   = rxShift_q;
    txShift_d   = txShift_q;
    addrHi_d    = addrHi_q;
    regAddr_d   = regAddr_q;
    wrData_d    = wrData_q;
    dataPhase_d = dataPhase_q;
    miso_d      = miso_q;
    misoOeN_d   = misoOeN_q;
    mode_d      = mode_q;
    if (csS) begin
      bitCnt_d    = '0;
      byteIdx_d   = IDX_COMMAND;
      wrCnt_d     = '0;
      dataPhase_d = 1'b0;
      mode_d      = MODE_NONE;
      misoOeN_d   = 1'b1;
    end else if (csFall) begin
      txShift_d = serialStatusByte;
      miso_d    = serialStatusByte[7];
      misoOeN_d = 1'b0;
    end else begin
      if (sclkRise) begin
        rxShift_d = rxByte[6:0];
        bitCnt_d  = bitCnt_q + 3'h1;
      end
      if (byteDone) begin
        byteIdx_d = (byteIdx_q == IDX_WRAP_TOP) ? IDX_WRAP_BASE : byteIdx_q + 3'h1;
        if (byteIdx_q == IDX_LAST_DUMMY)
          dataPhase_d = 1'b1;
        if (byteIdx_q == IDX_COMMAND) begin
          case (rxByte)
            CMD_LOAD_ADDRESS:     mode_d = MODE_ADDR;
            CMD_REGISTER_WRITE:   mode_d = MODE_WRITE;
            CMD_REGISTER_READ:    mode_d = MODE_READ;
            CMD_FAST_BUFFER_READ: mode_d = MODE_FAST;
            default:              mode_d = MODE_NONE;
          endcase
        end else if (mode_q == MODE_ADDR) begin
          if (byteIdx_q == IDX_ADDR_HIGH)
            addrHi_d = rxByte;
          else if (byteIdx_q == IDX_ADDR_LOW)
            regAddr_d = {addrHi_q, rxByte};
        end else if (mode_q == MODE_FAST && byteIdx_q[1:0] == SLOT_OFFSET) begin
          addrHi_d = rxByte;
        end else if (mode_q == MODE_WRITE && wrCnt_q < WR_FULL_BYTES) begin
          wrData_d = {wrData_q[23:0], rxByte};
          wrCnt_d  = wrCnt_q + 3'h1;
        end
      end
      if (sclkFall) begin
        if (bitCnt_q == '0) begin
          txShift_d = txSel;
          miso_d    = txSel[7];
        end else begin
          txShift_d = {txShift_q[6:0], 1'b0};
          miso_d    = txShift_q[6];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bitCnt_q    <= '0;
      byteIdx_q   <= IDX_COMMAND;
      wrCnt_q     <= '0;
      rxShift_q   <= '0;
      txShift_q   <= '0;
      txWord_q    <= '0;
      addrHi_q    <= '0;
      regAddr_q   <= '0;
      wrData_q    <= '0;
      dataPhase_q <= 1'b0;
      miso_q      <= 1'b0;
      misoOeN_q   <= 1'b1;
      mode_q      <= MODE_NONE;
    end else begin
      bitCnt_q    <= bitCnt_d;
      byteIdx_q   <= byteIdx_d;
      wrCnt_q     <= wrCnt_d;
      rxShift_q   <= rxShift_d;
      txShift_q   <= txShift_d;
      txWord_q    <= (sclkFall && bitCnt_q == '0) ? txWord_d : txWord_q;
      addrHi_q    <= addrHi_d;
      regAddr_q   <= regAddr_d;
      wrData_q    <= wrData_d;
      dataPhase_q <= dataPhase_d;
      miso_q      <= miso_d;
      misoOeN_q   <= misoOeN_d;
      mode_q      <= mode_d;
    end
  end
  // Internal bus master
  logic        wrReq, rdReq, fetchReq;
  logic        busReq_q, busReq_d, busWe_q, busWe_d, busWide_q, busWide_d, toPre_q, toPre_d;
  logic        underflow_q, underflow_d;
  logic [15:0] busAddr_q, busAddr_d;
  logic [31:0] busWdata_q, busWdata_d;

  assign wrReq    = csRise && mode_q == MODE_WRITE && (wrCnt_q == WR_HALF_BYTES || wrCnt_q == WR_FULL_BYTES);
  assign rdReq    = byteDone && byteIdx_q == IDX_COMMAND && rxByte == CMD_REGISTER_READ;
  // First offset fetches at once; later ones wait until the result ahead of them is loaded
  assign fetchReq = mode_q == MODE_FAST && ((byteDone && byteIdx_q == IDX_ADDR_HIGH) ||
                    (sclkFall && bitCnt_q == '0 && dataPhase_q && byteIdx_q[1:0] == SLOT_RESULT));
  assign fetchOff = (byteIdx_q == IDX_ADDR_HIGH) ? rxByte : addrHi_q;

  always_comb begin
    busReq_d    = busReq_q;
    busWe_d     = busWe_q;
    busWide_d   = busWide_q;
    busAddr_d   = busAddr_q;
    busWdata_d  = busWdata_q;
    toPre_d     = toPre_q;
    rdWord_d    = rdWord_q;
    pre_d       = pre_q;
    underflow_d = 1'b0;
    if (busReq_q && busAck) begin
      busReq_d = 1'b0;
      if (!busWe_q && toPre_q)
        pre_d = busRdata;
      else if (!busWe_q)
        rdWord_d = busRdWide ? busRdata : {busRdata[15:0], 16'h0000};
    end
    if (wrReq) begin
      busReq_d   = 1'b1;
      busWe_d    = 1'b1;
      busWide_d  = (wrCnt_q == WR_FULL_BYTES);
      busAddr_d  = regAddr_q;
      busWdata_d = wrData_q;
    end else if (rdReq) begin
      busReq_d  = 1'b1;
      busWe_d   = 1'b0;
      busAddr_d = regAddr_q;
      toPre_d   = 1'b0;
    end else if (fetchReq) begin
      busReq_d    = 1'b1;
      busWe_d     = 1'b0;
      busAddr_d   = RESULT_BUFFER_READ_PORT + {8'h00, fetchOff};
      toPre_d     = 1'b1;
      underflow_d = (fetchOff == 8'h00) && bufEmpty;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      busReq_q    <= 1'b0;
      busWe_q     <= 1'b0;
      busWide_q   <= 1'b0;
      busAddr_q   <= '0;
      busWdata_q  <= '0;
      toPre_q     <= 1'b0;
      rdWord_q    <= '0;
      pre_q       <= '0;
      underflow_q <= 1'b0;
    end else begin
      busReq_q    <= busReq_d;
      busWe_q     <= busWe_d;
      busWide_q   <= busWide_d;
      busAddr_q   <= busAddr_d;
      busWdata_q  <= busWdata_d;
      toPre_q     <= toPre_d;
      rdWord_q    <= rdWord_d;
      pre_q       <= pre_d;
      underflow_q <= underflow_d;
    end
  end
  assign miso         = miso_q;
  assign misoOeN      = misoOeN_q;
  assign underflowErr = underflow_q;
  assign busReq       = busReq_q;
  assign busWe        = busWe_q;
  assign busWide      = busWide_q;
  assign busAddr      = busAddr_q;
  assign busWdata     = busWdata_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence selRelease;
    csRise;
  endsequence

  a_idle_ignores: assert property (csS |=> bitCnt_q == '0 && mode_q == MODE_NONE)
    else $error("serial state moved while deselected");
  a_miso_on_fall: assert property ($changed(miso_q) |-> $past(sclkFall || csFall))
    else $error("data out changed off a falling edge");
  a_msb_first: assert property (sclkFall && bitCnt_q == '0 |=> miso_q == txShift_q[7])
    else $error("byte not sent most significant bit first");
  a_abandon_frame: assert property (selRelease |=> byteIdx_q == IDX_COMMAND && !dataPhase_q)
    else $error("frame not abandoned on select release");
  a_addr_persist: assert property (selRelease |=> $stable(regAddr_q))
    else $error("stored address lost on select release");
  a_write_issue: assert property (wrReq |=> busReq_q && busWe_q && busAddr_q == $past(regAddr_q))
    else $error("register write not issued");
  a_read_issue: assert property (rdReq |=> busReq_q && !busWe_q && !toPre_q)
    else $error("register read not issued");
  a_fetch_addr: assert property (fetchReq |=> busReq_q && busAddr_q == RESULT_BUFFER_READ_PORT + {8'h00, $past(fetchOff)})
    else $error("prefetch address wrong");
  a_underflow: assert property (fetchReq && fetchOff == 8'h00 && bufEmpty |=> underflow_q ##1 !underflow_q)
    else $error("underflow not flagged for one cycle");
  a_status_out: assert property (csFall |=> txShift_q == $past(serialStatusByte) && !misoOeN_q)
    else $error("status byte not loaded at frame start");
  a_addr_load: assert property (byteDone && mode_q == MODE_ADDR && byteIdx_q == IDX_ADDR_LOW
                                |=> regAddr_q == {addrHi_q, $past(rxByte)})
    else $error("address not loaded");

endmodule

// File: tb/scp_host_model.sv
// Serial host model: select, clock and data out, captures data in
module scp_host_model (
  // Pacing clock
  input  wire logic clock,
  // Serial pins
  output logic      csN,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic misoOeN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txB [20];
  logic [7:0] rxB [20];

  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // Four clocks a phase: 160 ns period
  task automatic half();
    repeat (4) @(posedge clock);
  endtask

  // Whole bytes, MSB first, select low around every clock edge
  task automatic frame(input int n);
    @(posedge clock) csN <= 1'b0;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        half();
        sclk <= 1'b0;
        mosi <= txB[b][i];
        half();
        sclk <= 1'b1;
        @(negedge clock);
        rxB[b][i] = misoOeN ? 1'bx : miso;
      end
    end
    half();
    sclk <= 1'b0;
    half();
    csN <= 1'b1;
    mosi <= ~mosi;
    half();
  endtask

  // Clock and data activity while deselected
  task automatic noise(input int n);
    repeat (n) begin
      @(posedge clock);
      sclk <= ~sclk;
      mosi <= 1'($urandom);
    end
    @(posedge clock) sclk <= 1'b0;
    half();
  endtask
endmodule

// File: tb/tb_scp_top.sv
// Self-checking bench of the serial command port
module tb_scp_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;
  logic        clock = 1'b0;
  logic        rst, csN, sclk, mosi, miso, misoOeN, bufEmpty, underflowErr, nextWide;
  logic        busReq, busWe, busWide, busAck, busRdWide, reqPrev = 1'b0;
  logic [7:0]  statusByte;
  logic [15:0] busAddr, curAddr;
  logic [31:0] busWdata, busRdata, rnd;
  logic [49:0] e;
  logic [49:0] expQ [$];
  logic [31:0] rdQ [$];
  int          lat = 0, nUf = 0, expUf = 0, cyc = 0, n_mismatch = 0, samples_checked = 0;

  always #10 clock = ~clock;

  scp_top u_dut (.clock(clock), .rst(rst), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso),
    .misoOeN(misoOeN), .serialStatusByte(statusByte), .bufEmpty(bufEmpty), .underflowErr(underflowErr),
    .busReq(busReq), .busWe(busWe), .busWide(busWide), .busAddr(busAddr), .busWdata(busWdata),
    .busAck(busAck), .busRdata(busRdata), .busRdWide(busRdWide));
  scp_host_model u_host (.clock(clock), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso), .misoOeN(misoOeN));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s: %h, expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d, compares %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Internal bus responder: takes the oldest note at each new request
  always @(posedge clock) begin
    busAck <= 1'b0;
    cyc++;
    if (underflowErr === 1'b1) nUf++;
    if (busReq === 1'b1 && !reqPrev) begin
      if (expQ.size() == 0) begin
        check(32'h1, 32'h0, "unexpected request");
      end else begin
        e = expQ.pop_front();
        check({14'h0, busWe, busWe & busWide, busAddr}, {14'h0, e[49:32]}, "request");
        if (e[49]) check(e[48] ? busWdata : {16'h0, busWdata[15:0]}, e[31:0], "write data");
      end
      lat <= 1 + $urandom % 5;
    end
    if (lat == 1) begin
      rnd = $urandom;
      busAck <= 1'b1;
      busRdata <= rnd;
      busRdWide <= nextWide;
      if (!busWe) rdQ.push_back(rnd);
    end
    if (lat != 0) lat <= lat - 1;
    reqPrev <= busReq === 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic setAddr(input logic [15:0] a);
    {u_host.txB[0], u_host.txB[1], u_host.txB[2]} = {CMD_LOAD_ADDRESS, a};
    curAddr = a;
    u_host.frame(3);
  endtask

  task automatic regWrite(input logic w, input logic [31:0] d);
    logic [31:0] x;
    x = w ? d : {d[15:0], 16'h0};
    u_host.txB[0] = CMD_REGISTER_WRITE;
    for (int i = 0; i < 4; i++) u_host.txB[i + 1] = x[31 - 8 * i -: 8];
    expQ.push_back({1'b1, w, curAddr, w ? d : {16'h0, d[15:0]}});
    u_host.frame(w ? 5 : 3);
  endtask

  task automatic regRead(input logic w);
    logic [31:0] x;
    u_host.txB[0] = CMD_REGISTER_READ;
    u_host.txB[1] = 8'($urandom);
    nextWide <= w;
    expQ.push_back({2'b00, curAddr, 32'h0});
    u_host.frame(w ? 6 : 4);
    x = rdQ.pop_front();
    check({u_host.rxB[2], u_host.rxB[3], w ? {u_host.rxB[4], u_host.rxB[5]} : 16'h0},
          w ? x : {x[15:0], 16'h0}, "read data");
  endtask

  // Offset bytes sit at 1, 5, 9...; first two use o1, later ones o2
  task automatic fast(input int n, input logic emp, input logic [7:0] o1, input logic [7:0] o2);
    logic [7:0]  s;
    logic [31:0] x;
    s = 8'($urandom);
    statusByte <= s;
    bufEmpty <= emp;
    nextWide <= 1'b1;
    u_host.txB[0] = CMD_FAST_BUFFER_READ;
    for (int i = 1; i < n; i++) u_host.txB[i] = (i % 4 == 1) ? (i < 9 ? o1 : o2) : 8'($urandom);
    for (int i = 1; i < n; i += 4) begin
      expQ.push_back({2'b00, RESULT_BUFFER_READ_PORT + 16'(u_host.txB[i]), 32'h0});
      expUf += int'(emp && u_host.txB[i] == 8'h00);
    end
    u_host.frame(n);
    for (int i = 0; i < 7 && i < n; i++) check(32'(u_host.rxB[i]), 32'(s), "status byte");
    for (int k = 0; 1 + 4 * k < n; k++) begin
      x = rdQ.pop_front();
      if (10 + 4 * k < n) check({u_host.rxB[7 + 4 * k], u_host.rxB[8 + 4 * k], u_host.rxB[9 + 4 * k],
                                 u_host.rxB[10 + 4 * k]}, x, "result");
    end
  endtask

  initial begin
    rst = 1'b1;
    statusByte = 8'h00;
    bufEmpty = 1'b0;
    busAck = 1'b0;
    busRdata = 32'h0;
    busRdWide = 1'b0;
    nextWide = 1'b0;
    void'($urandom(12));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check({29'h0, miso, misoOeN, busReq}, 32'h2, "reset outputs");
    $display("test reset done");
    for (int w = 0; w < 2; w++) begin
      setAddr(16'($urandom));
      regWrite(w[0], $urandom);
      regRead(w[0]);
      regRead(~w[0]);
    end
    $display("test register access done");
    u_host.txB[0] = CMD_REGISTER_WRITE;
    u_host.frame(4);
    u_host.noise(40);
    regRead(1'b1);
    $display("test abort and deselected noise done");
    fast(19, 1'b0, 8'h00, 8'h04);
    fast(2, 1'b1, 8'h00, 8'h00);
    fast(2, 1'b1, 8'h08, 8'h00);
    u_host.txB[0] = 8'h33;
    u_host.frame(3);
    for (int i = 0; i < 3; i++) check(32'(u_host.rxB[i]), 32'(statusByte), "unknown command");
    repeat (20) @(posedge clock);
    check(32'(nUf), 32'(expUf), "underflow count");
    check(32'(expQ.size()), 32'h0, "missing requests");
    $display("test fast read done");
    end_sim();
  end
endmodule
